//--- hdl/debug_watchpoint_control.sv
// design: debug entry, saved state, watchpoints and their register file
//
// Summary of operation
// - on debug entry the current stack pointer is saved into a register
// - core select register holds an 8-bit core number, upper bits zero
// - register select holds a 5-bit register number, upper bits zero
// - a read-only register reports what caused the current debug entry
// - four watchpoints, each with mask, value and control registers
// - control bits 23:16 enable the watchpoint per logical core
// - sense clear: trigger when masked resource id equals the value
// - sense set: trigger when masked resource id differs from value
// - control bit 0 enables the watchpoint; all control resets to zero
// - a read-only bit shows one while in debug mode, reset zero
// - writing one to request bit 0 asks for a debug interrupt
// - origin bit 4 set when the external pin caused the last entry
// - origin bit 0 set when the tile itself caused the last entry
`timescale 1ns/1ps
`default_nettype none
module debug_watchpoint_control
  import debug_watch_pkg::*;
#(
  parameter int unsigned NUM_WP = 4,
  parameter int unsigned NUM_CORES = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic debug_req_n,
  input wire logic [31:0] current_pc,
  input wire logic [31:0] current_sp,
  input wire logic debug_exit,
  input wire logic res_valid,
  input wire logic [31:0] res_id,
  input wire logic [2:0] res_core,
  output logic debug_irq,
  output logic in_debug,
  output logic [7:0] fetch_core,
  output logic [4:0] fetch_reg,
  output logic irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] rdata;
    logic wait_q;
    logic req;
    logic mode;
    logic [31:0] saved_program_counter;
    logic [31:0] saved_stack_pointer;
    logic [7:0] core_sel;
    logic [4:0] reg_sel;
    logic [2:0] cause;
    logic org_pin;
    logic org_tile;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    logic irq_q;
    logic [NUM_WP-1:0][31:0] wp_mask;
    logic [NUM_WP-1:0][31:0] wp_value;
    logic [NUM_WP-1:0][7:0] wp_cores;
    logic [NUM_WP-1:0] wp_inv;
    logic [NUM_WP-1:0] wp_en;
  } state_t;

  state_t cur;
  state_t next_st;

  logic [7:0] idx;
  logic wr_go;
  logic [NUM_WP-1:0] wp_hit;
  logic any_hit;
  logic pin_ev;
  logic sw_ev;
  logic enter;

  assign idx = address[9:2];
  assign wr_go = write && !cur.wait_q;

  // ---------------------------------------------------------------
  // watchpoint compare
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_WP; i++) begin
      wp_hit[i] = res_valid && cur.wp_en[i]
        && cur.wp_cores[i][res_core]
        && (((res_id & cur.wp_mask[i]) == cur.wp_value[i])
            != cur.wp_inv[i]);
    end
  end

  assign any_hit = |wp_hit;
  assign pin_ev = !debug_req_n;
  assign sw_ev = cur.req;
  assign enter = !cur.mode && (pin_ev || sw_ev || any_hit);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] rd;
    logic [7:0] sub;
    rd = RESET_WORD;
    sub = 8'h00;
    next_st = cur;

    // bus handshake: one wait cycle, then answer
    next_st.wait_q = !((read || write) && cur.wait_q);

    // read mux
    unique case (idx)
      IDX_CAUSE_REQUEST: begin
        rd[CAUSE_REQ_BIT] = cur.req;
        rd[CAUSE_MODE_BIT] = cur.mode;
      end
      IDX_SAVED_PC: rd = cur.saved_program_counter;
      IDX_SAVED_SP: rd = cur.saved_stack_pointer;
      IDX_CORE_SELECT: rd[CORE_SEL_W-1:0] = cur.core_sel;
      IDX_REG_SELECT: rd[REG_SEL_W-1:0] = cur.reg_sel;
      IDX_IRQ_TYPE: rd[2:0] = cur.cause;
      IDX_EVENT_ORIGIN: begin
        rd[ORIGIN_PIN_BIT] = cur.org_pin;
        rd[ORIGIN_TILE_BIT] = cur.org_tile;
      end
      IDX_INT_STATUS: rd[1:0] = cur.int_stat;
      IDX_INT_MASK: rd[1:0] = cur.int_mask;
      default: begin
        for (int i = 0; i < NUM_WP; i++) begin
          sub = 8'(i);
          if (idx == IDX_WP_MASK + sub) begin
            rd = cur.wp_mask[i];
          end
          if (idx == IDX_WP_VALUE + sub) begin
            rd = cur.wp_value[i];
          end
          if (idx == IDX_WP_CONTROL + sub) begin
            rd[WP_CORE_LSB +: 8] = cur.wp_cores[i];
            rd[WP_INV_BIT] = cur.wp_inv[i];
            rd[WP_EN_BIT] = cur.wp_en[i];
          end
        end
      end
    endcase
    if (read && cur.wait_q) begin
      next_st.rdata = rd;
    end

    // writes take effect at the accepting edge
    if (wr_go) begin
      unique case (idx)
        IDX_CAUSE_REQUEST: begin
          if (writedata[CAUSE_REQ_BIT]) begin
            next_st.req = 1'b1;
          end
        end
        IDX_SAVED_PC: begin
          if (cur.mode) begin
            next_st.saved_program_counter = writedata;
          end
        end
        IDX_SAVED_SP: begin
          if (cur.mode) begin
            next_st.saved_stack_pointer = writedata;
          end
        end
        IDX_CORE_SELECT: begin
          if (cur.mode) begin
            next_st.core_sel = writedata[CORE_SEL_W-1:0];
          end
        end
        IDX_REG_SELECT: begin
          if (cur.mode) begin
            next_st.reg_sel = writedata[REG_SEL_W-1:0];
          end
        end
        IDX_EVENT_ORIGIN: begin
          next_st.org_pin = writedata[ORIGIN_PIN_BIT];
          next_st.org_tile = writedata[ORIGIN_TILE_BIT];
        end
        IDX_INT_STATUS: next_st.int_stat = cur.int_stat & ~writedata[1:0];
        IDX_INT_MASK: next_st.int_mask = writedata[1:0];
        default: begin
          for (int i = 0; i < NUM_WP; i++) begin
            sub = 8'(i);
            if (cur.mode && idx == IDX_WP_MASK + sub) begin
              next_st.wp_mask[i] = writedata;
            end
            if (cur.mode && idx == IDX_WP_VALUE + sub) begin
              next_st.wp_value[i] = writedata;
            end
            if (cur.mode && idx == IDX_WP_CONTROL + sub) begin
              next_st.wp_cores[i] = writedata[WP_CORE_LSB +: 8];
              next_st.wp_inv[i] = writedata[WP_INV_BIT];
              next_st.wp_en[i] = writedata[WP_EN_BIT];
            end
          end
        end
      endcase
    end

    // debug entry and exit
    if (enter) begin
      next_st.mode = 1'b1;
      next_st.saved_program_counter = current_pc;
      next_st.saved_stack_pointer = current_sp;
      next_st.req = 1'b0;
      next_st.cause = (sw_ev ? TYPE_SOFTWARE : 3'h0)
        | (pin_ev ? TYPE_PIN : 3'h0)
        | (any_hit ? TYPE_WATCH : 3'h0);
      next_st.org_pin = pin_ev;
      next_st.org_tile = sw_ev || any_hit;
    end else if (cur.mode && debug_exit) begin
      next_st.mode = 1'b0;
    end

    // sticky interrupt status, set wins over clear
    if (enter) begin
      next_st.int_stat[INT_ENTRY_BIT] = 1'b1;
    end
    if (any_hit) begin
      next_st.int_stat[INT_WATCH_BIT] = 1'b1;
    end
    next_st.irq_q = |(next_st.int_stat & next_st.int_mask);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cur <= '0;
      cur.wait_q <= 1'b1;
      cur.wp_cores <= {NUM_WP{WP_CONTROL_RESET[WP_CORE_LSB +: 8]}};
      cur.wp_inv <= '0;
      cur.wp_en <= '0;
    end else begin
      cur <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign readdata = cur.rdata;
  assign waitrequest = cur.wait_q;
  assign debug_irq = cur.mode;
  assign in_debug = cur.mode;
  assign fetch_core = cur.core_sel;
  assign fetch_reg = cur.reg_sel;
  assign irq = cur.irq_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_enter_cond;
    !in_debug && (pin_ev || sw_ev || any_hit);
  endsequence

  sequence s_in_debug;
    in_debug;
  endsequence

  a_sp_capture: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_enter_cond |=> cur.saved_stack_pointer == $past(current_sp))
    else $error("stack pointer not saved on entry");

  a_core_sel_hold: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !in_debug |=> $stable(fetch_core))
    else $error("core select changed outside debug mode");

  a_reg_sel_hold: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !in_debug |=> $stable(fetch_reg))
    else $error("register select changed outside debug mode");

  a_cause_code: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_enter_cond ##0 pin_ev |=> cur.cause[1])
    else $error("cause code misses the pin");

  a_watch_enter: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !in_debug && any_hit |=> s_in_debug ##0 cur.cause[2])
    else $error("watchpoint hit did not enter debug");

  a_wp_disabled: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    cur.wp_en == '0 |-> !any_hit)
    else $error("disabled watchpoint triggered");

  a_mode_entry: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_enter_cond |=> s_in_debug ##1 (in_debug || $past(debug_exit)))
    else $error("debug mode bit wrong after entry");

  a_sw_request: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    wr_go && idx == IDX_CAUSE_REQUEST && writedata[0] && !in_debug
    |-> ##[1:2] in_debug)
    else $error("software request did not enter debug");

  a_pin_origin: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_enter_cond ##0 pin_ev |=> cur.org_pin && in_debug)
    else $error("pin origin not recorded");

  a_tile_origin: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_enter_cond ##0 !pin_ev |=> cur.org_tile && !cur.org_pin)
    else $error("tile origin not recorded");

  a_pc_locked: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !in_debug && !enter |=> $stable(cur.saved_program_counter))
    else $error("saved pc changed outside debug mode");

  a_bus_answer: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer not given in one cycle");

  a_exit_mode: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    in_debug && debug_exit |=> !in_debug)
    else $error("debug mode not left on exit");

  a_req_cleared: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_enter_cond |=> !cur.req && debug_irq)
    else $error("request not cleared or interrupt not raised");

  a_sp_locked: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !in_debug && !enter |=> $stable(cur.saved_stack_pointer))
    else $error("saved sp changed outside debug mode");

  a_wp_locked: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !in_debug |=> $stable({cur.wp_mask, cur.wp_value})
      && $stable({cur.wp_cores, cur.wp_inv, cur.wp_en}))
    else $error("watchpoint changed outside debug mode");

  a_core_reserved: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    read && waitrequest && idx == IDX_CORE_SELECT
    |=> readdata[31:CORE_SEL_W] == '0)
    else $error("core select reserved bits not zero");

endmodule
`default_nettype wire

//--- include/debug_watch_pkg.sv
// package: register map, field positions and reset values for debug control
package debug_watch_pkg;

  // ---------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CAUSE_REQUEST = 8'h05;
  localparam logic [7:0] IDX_SAVED_PC = 8'h11;
  localparam logic [7:0] IDX_SAVED_SP = 8'h12;
  localparam logic [7:0] IDX_CORE_SELECT = 8'h13;
  localparam logic [7:0] IDX_REG_SELECT = 8'h14;
  localparam logic [7:0] IDX_IRQ_TYPE = 8'h15;
  localparam logic [7:0] IDX_EVENT_ORIGIN = 8'h1f;
  localparam logic [7:0] IDX_INT_STATUS = 8'h30;
  localparam logic [7:0] IDX_INT_MASK = 8'h31;
  localparam logic [7:0] IDX_WP_MASK = 8'h80;
  localparam logic [7:0] IDX_WP_VALUE = 8'h90;
  localparam logic [7:0] IDX_WP_CONTROL = 8'h9c;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CAUSE_REQ_BIT = 0;
  localparam int unsigned CAUSE_MODE_BIT = 1;
  localparam int unsigned ORIGIN_TILE_BIT = 0;
  localparam int unsigned ORIGIN_PIN_BIT = 4;
  localparam int unsigned WP_EN_BIT = 0;
  localparam int unsigned WP_INV_BIT = 1;
  localparam int unsigned WP_CORE_LSB = 16;
  localparam int unsigned CORE_SEL_W = 8;
  localparam int unsigned REG_SEL_W = 5;
  localparam int unsigned INT_ENTRY_BIT = 0;
  localparam int unsigned INT_WATCH_BIT = 1;

  // ---------------------------------------------------------------
  // cause codes in the interrupt type register
  // ---------------------------------------------------------------
  localparam logic [2:0] TYPE_SOFTWARE = 3'h1;
  localparam logic [2:0] TYPE_PIN = 3'h2;
  localparam logic [2:0] TYPE_WATCH = 3'h4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] WP_CONTROL_RESET = 32'h0000_0000;

endpackage

//--- verification/debug_far_side.sv
// partner: external debug pin and processor state seen by the block
`timescale 1ns/1ps
`default_nettype none
module debug_far_side (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic pin_req,
  input wire logic [31:0] state_word,
  output logic debug_req_n,
  output logic [31:0] current_pc,
  output logic [31:0] current_sp
);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      debug_req_n <= 1'b1;
    end else begin
      debug_req_n <= ~pin_req;
    end
    current_sp <= state_word;
    current_pc <= ~state_word;
  end
endmodule
`default_nettype wire

//--- verification/tb_debug_watchpoint_control.sv
// testbench: registers, debug entry, watchpoints and interrupt
`timescale 1ns/1ps
`default_nettype none
module tb_debug_watchpoint_control;
  import debug_watch_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic debug_exit = 1'b0;
  logic res_valid = 1'b0;
  logic pin_req = 1'b0;
  logic [9:0] address = 10'h000;
  logic [2:0] res_core = 3'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] res_id = 32'h0;
  logic [31:0] state_word = 32'h0;
  logic [31:0] seed = 32'hcb815d50;
  logic [31:0] rd, readdata, current_pc, current_sp, id;
  logic [31:0] wm [4];
  logic [31:0] wv [4];
  logic [31:0] wc [4];
  logic waitrequest, debug_req_n, debug_irq, in_debug, irq, exp;
  logic [7:0] fetch_core;
  logic [4:0] fetch_reg;
  int mismatches = 0;
  int check_count = 0;

  always #2 core_clk = ~core_clk;

  debug_watchpoint_control debug_watchpoint_control_inst (
    .core_clk, .sys_rst, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .debug_req_n, .current_pc, .current_sp, .debug_exit,
    .res_valid, .res_id, .res_core, .debug_irq, .in_debug, .fetch_core,
    .fetch_reg, .irq
  );
  debug_far_side debug_far_side_inst (
    .core_clk, .sys_rst, .pin_req, .state_word, .debug_req_n, .current_pc,
    .current_sp
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0);
  endfunction

  function automatic logic wp_hit(input logic [31:0] a, input logic [2:0] c);
    logic h;
    h = 1'b0;
    for (int i = 0; i < 4; i++) begin
      h |= wc[i][0] & wc[i][16 + c] & (((a & wm[i]) == wv[i]) ^ wc[i][1]);
    end
    return h;
  endfunction

  task automatic check_word(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: word %h want %h", $time, got, want);
    end
  endtask

  task automatic check_bit(input logic got, input logic want);
    check_count++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: bit %b want %b", $time, got, want);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    address <= {idx, 2'b00};
    read <= ~wr;
    write <= wr;
    writedata <= wd;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("unexpected at %0t: no bus answer", $time);
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wait_debug(input logic want);
    int n;
    n = 0;
    while (in_debug !== want && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    check_bit(in_debug, want);
    check_bit(debug_irq, want);
  endtask

  task automatic exit_debug;
    @(posedge core_clk);
    debug_exit <= 1'b1;
    @(posedge core_clk);
    debug_exit <= 1'b0;
    wait_debug(1'b0);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #80000;
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run;
  end

  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    bus(1'b0, IDX_CAUSE_REQUEST, 32'h0);
    check_word(rd, RESET_WORD);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, IDX_WP_CONTROL + 8'(i), 32'h0);
      check_word(rd, WP_CONTROL_RESET);
    end
    bus(1'b0, 8'h3f, 32'h0);
    check_word(rd, 32'h0);
    bus(1'b1, IDX_CORE_SELECT, 32'h0000_005a);
    bus(1'b0, IDX_CORE_SELECT, 32'h0);
    check_word(rd, 32'h0);
    $display("test reset done");
    seed = lfsr(seed);
    state_word <= seed;
    bus(1'b1, IDX_CAUSE_REQUEST, 32'h1);
    wait_debug(1'b1);
    bus(1'b0, IDX_CAUSE_REQUEST, 32'h0);
    check_word(rd, 32'h2);
    bus(1'b0, IDX_SAVED_SP, 32'h0);
    check_word(rd, state_word);
    bus(1'b0, IDX_IRQ_TYPE, 32'h0);
    check_word(rd, {29'h0, TYPE_SOFTWARE});
    bus(1'b0, IDX_EVENT_ORIGIN, 32'h0);
    check_bit(rd[ORIGIN_TILE_BIT], 1'b1);
    check_bit(rd[ORIGIN_PIN_BIT], 1'b0);
    bus(1'b1, IDX_CORE_SELECT, 32'hffff_ffff);
    bus(1'b1, IDX_REG_SELECT, 32'hffff_ffff);
    bus(1'b0, IDX_CORE_SELECT, 32'h0);
    check_word(rd, 32'h0000_00ff);
    bus(1'b0, IDX_REG_SELECT, 32'h0);
    check_word(rd, 32'h0000_001f);
    check_word({19'h0, fetch_reg, fetch_core}, 32'h1fff);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wm[i] = 32'hf | (seed & 32'hf0);
      wv[i] = seed & 32'hf;
      wc[i] = (seed & 32'hffff_fffc) | {30'h0, i[0], 1'(i != 3)};
      bus(1'b1, IDX_WP_MASK + 8'(i), wm[i]);
      bus(1'b1, IDX_WP_VALUE + 8'(i), wv[i]);
      bus(1'b1, IDX_WP_CONTROL + 8'(i), wc[i]);
      wc[i] = wc[i] & 32'h00ff_0003;
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, IDX_WP_MASK + 8'(i), 32'h0);
      check_word(rd, wm[i]);
      bus(1'b0, IDX_WP_VALUE + 8'(i), 32'h0);
      check_word(rd, wv[i]);
      bus(1'b0, IDX_WP_CONTROL + 8'(i), 32'h0);
      check_word(rd, wc[i]);
    end
    exit_debug;
    $display("test setup done");
    for (int k = 0; k < 60; k++) begin
      seed = lfsr(seed);
      id = {seed[31:4], k[1] ? seed[3:0] : wv[k % 4][3:0]};
      exp = wp_hit(id, seed[6:4]);
      @(posedge core_clk);
      res_valid <= 1'b1;
      res_id <= id;
      res_core <= seed[6:4];
      @(posedge core_clk);
      res_valid <= 1'b0;
      @(posedge core_clk);
      check_bit(in_debug, exp);
      if (exp) begin
        exit_debug;
      end
    end
    $display("test watch done");
    @(posedge core_clk);
    pin_req <= 1'b1;
    wait_debug(1'b1);
    bus(1'b0, IDX_EVENT_ORIGIN, 32'h0);
    check_bit(rd[ORIGIN_PIN_BIT], 1'b1);
    check_bit(rd[ORIGIN_TILE_BIT], 1'b0);
    bus(1'b0, IDX_IRQ_TYPE, 32'h0);
    check_word(rd, {29'h0, TYPE_PIN});
    pin_req <= 1'b0;
    repeat (3) @(posedge core_clk);
    exit_debug;
    $display("test pin done");
    bus(1'b1, IDX_INT_MASK, 32'h0);
    repeat (2) @(posedge core_clk);
    check_bit(irq, 1'b0);
    bus(1'b1, IDX_INT_MASK, 32'h1);
    repeat (2) @(posedge core_clk);
    check_bit(irq, 1'b1);
    bus(1'b1, IDX_INT_STATUS, 32'h1);
    repeat (2) @(posedge core_clk);
    check_bit(irq, 1'b0);
    $display("test interrupt done");
    complete_run;
  end
endmodule
`default_nettype wire
